// ==== rtl/rbcp_pkg.sv ====
// shared constants, types and encodings of the relay bank command parser
package rbcp_pkg;
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned MS_TIME_MS    = 1;
   localparam int unsigned MS_CYC        = CLK_HZ / 1000 * MS_TIME_MS;
   localparam int unsigned PWRUP_TIME_S  = 5;
   localparam int unsigned PWRUP_CYC     = CLK_HZ * PWRUP_TIME_S;
   localparam logic [7:0]  BLINK_MS      = 8'hfa;
   localparam int unsigned NUM_RELAYS    = 32;
   localparam logic [16:0] MAX_IDX       = 17'h0001f;
   localparam logic [16:0] MAX_DLY       = 17'h0ffff;
   localparam logic [2:0]  IDX_DIGITS    = 3'h2;
   localparam logic [2:0]  DLY_DIGITS    = 3'h5;

   localparam logic [7:0]  ASC_LF        = 8'h0a;
   localparam logic [7:0]  ASC_CR        = 8'h0d;
   localparam logic [7:0]  ASC_ZERO      = 8'h30;
   localparam logic [7:0]  ASC_NINE      = 8'h39;
   localparam logic [7:0]  ASC_LOW_A     = 8'h61;
   localparam logic [7:0]  ASC_LOW_Z     = 8'h7a;
   localparam logic [7:0]  ASC_CASE      = 8'h20;
   localparam logic [7:0]  CMD_CLOSE     = 8'h43;
   localparam logic [7:0]  CMD_OPEN      = 8'h4f;
   localparam logic [7:0]  CMD_DELAY     = 8'h44;
   localparam logic [7:0]  CMD_RESET     = 8'h52;
   localparam logic [7:0]  CMD_SET       = 8'h53;
   localparam logic [7:0]  CMD_QUERY     = 8'h51;
   localparam logic [7:0]  CMD_TIME      = 8'h54;
   localparam logic [7:0]  CMD_IDENT     = 8'h49;

   // identity text is arbitrary, it names no real maker or part
   localparam logic [4:0]   ID_LEN       = 5'h18;
   localparam logic [191:0] ID_STR       = "NONE RB32;RELAY;1.0;0000";
   localparam logic [4:0]   STAT_LEN     = 5'h01;
   localparam logic [4:0]   TIME_LEN     = 5'h05;

   typedef enum logic [5:0] {
      ST_BOOT = 6'h01,
      ST_IDLE = 6'h02,
      ST_ARG  = 6'h04,
      ST_EXEC = 6'h08,
      ST_WAIT = 6'h10,
      ST_SEND = 6'h20
   } rbcp_state_e;

   typedef enum logic [1:0] {
      RESP_NONE = 2'h0,
      RESP_STAT = 2'h1,
      RESP_TIME = 2'h2,
      RESP_ID   = 2'h3
   } rbcp_resp_e;

   typedef struct packed {
      logic [7:0] data;
      logic       eom;
   } rbcp_byte_s;
endpackage : rbcp_pkg

// ==== rtl/rbcp_top.sv ====
// relay bank command parser: ascii command stream in, 32 relays and replies out
`timescale 1ns/1ps
module rbcp_top #(
   parameter int unsigned PWRUP_CYC = rbcp_pkg::PWRUP_CYC,
   parameter int unsigned MS_CYC    = rbcp_pkg::MS_CYC
) (
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire rbcp_pkg::rbcp_byte_s rx,
   input  wire logic                rx_valid,
   output logic                     rx_ready,
   output rbcp_pkg::rbcp_byte_s     tx,
   output logic                     tx_valid,
   input  wire logic                tx_ready,
   input  wire logic                ws_cmd_valid,
   input  wire logic                ws_cmd_supported,
   output logic                     ws_unsup_err,
   output logic [31:0]              relay,
   output logic [31:0]              chan_led,
   output logic                     power_led,
   output logic                     msg_led
);
   rbcp_pkg::rbcp_state_e state, next_state;
   rbcp_pkg::rbcp_resp_e  resp, exec_resp;
   rbcp_pkg::rbcp_byte_s  held, in_b, spare, push_b;
   logic        held_v, next_held_v, hold_it, take;
   logic [25:0] pwr_cnt;
   logic [13:0] pscale;
   logic        ms_tick;
   logic [7:0]  blink_cnt;
   logic [7:0]  cmd, c;
   logic [2:0]  kwi, ndig, maxd;
   logic [16:0] acc;
   logic [19:0] bcd, dly_bcd;
   logic [15:0] dly, ms_left;
   logic [4:0]  sel, idx, sidx, body_len;
   logic [3:0]  dval;
   logic        term, is_dig, is_cmd, is_term, kw_hit, dig_ok, valid_idx, exec_wait;
   logic        spare_v, push, skip, last;
   logic [7:0]  out_c;
   logic [2:0]  lead;

   // folding case here lets every comparison below use upper case only
   function automatic logic [7:0] upcase(input logic [7:0] ch);
      upcase = (ch >= rbcp_pkg::ASC_LOW_A && ch <= rbcp_pkg::ASC_LOW_Z) ? ch - rbcp_pkg::ASC_CASE : ch;
   endfunction : upcase

   // letters that follow the short form in the long keyword
   function automatic logic [7:0] kw_char(input logic [7:0] op, input logic [2:0] i);
      logic [63:0] s;
      logic [2:0]  n;
      s = 64'h0;
      n = 3'h0;
      case (op)
         rbcp_pkg::CMD_CLOSE: begin s = 64'("LOSE");  n = 3'h4; end
         rbcp_pkg::CMD_OPEN:  begin s = 64'("PEN");   n = 3'h3; end
         rbcp_pkg::CMD_DELAY: begin s = 64'("ELAY");  n = 3'h4; end
         rbcp_pkg::CMD_RESET: begin s = 64'("ESET");  n = 3'h4; end
         rbcp_pkg::CMD_SET:   begin s = 64'("ET");    n = 3'h2; end
         rbcp_pkg::CMD_QUERY: begin s = 64'("UERY?"); n = 3'h5; end
         rbcp_pkg::CMD_TIME:  begin s = 64'("IME?");  n = 3'h4; end
         rbcp_pkg::CMD_IDENT: begin s = 64'("DN?");   n = 3'h3; end
         default:             begin s = 64'h0;        n = 3'h0; end
      endcase
      kw_char = (i < n) ? s[8 * (int'(n) - 1 - int'(i)) +: 8] : 8'h00;
   endfunction : kw_char

   // decode of the byte on offer, either a held-over byte or the stream
   always_comb begin
      in_b    = held_v ? held : rx;
      take    = held_v | (rx_valid & rx_ready);
      c       = upcase(in_b.data);
      is_dig  = (c >= rbcp_pkg::ASC_ZERO) && (c <= rbcp_pkg::ASC_NINE);
      dval    = 4'(c - rbcp_pkg::ASC_ZERO);
      is_term = (c == rbcp_pkg::ASC_LF) || in_b.eom;
      is_cmd  = (kw_char(c, 3'h0) != 8'h00);
      case (cmd)
         rbcp_pkg::CMD_DELAY: maxd = rbcp_pkg::DLY_DIGITS;
         rbcp_pkg::CMD_TIME,
         rbcp_pkg::CMD_IDENT: maxd = 3'h0;
         default:             maxd = rbcp_pkg::IDX_DIGITS;
      endcase
      dig_ok    = is_dig && (ndig < maxd);
      kw_hit    = (ndig == 3'h0) && (c != 8'h00) && (c == kw_char(cmd, kwi));
      idx       = acc[4:0];
      valid_idx = (ndig != 3'h0) && (acc <= rbcp_pkg::MAX_IDX);
      exec_wait = valid_idx && (dly != 16'h0) && (cmd == rbcp_pkg::CMD_CLOSE || cmd == rbcp_pkg::CMD_OPEN ||
                  cmd == rbcp_pkg::CMD_QUERY || cmd == rbcp_pkg::CMD_RESET || cmd == rbcp_pkg::CMD_SET);
      case (cmd)
         rbcp_pkg::CMD_QUERY: exec_resp = rbcp_pkg::RESP_STAT;
         rbcp_pkg::CMD_TIME:  exec_resp = rbcp_pkg::RESP_TIME;
         rbcp_pkg::CMD_IDENT: exec_resp = rbcp_pkg::RESP_ID;
         default:             exec_resp = resp;
      endcase
   end

   always_comb begin
      next_state = state;
      hold_it    = 1'b0;
      case (state)
         rbcp_pkg::ST_BOOT: begin
            if (pwr_cnt == 26'(PWRUP_CYC - 1)) next_state = rbcp_pkg::ST_IDLE;
         end
         rbcp_pkg::ST_IDLE: begin
            if (take && is_cmd) begin
               next_state = in_b.eom ? rbcp_pkg::ST_EXEC : rbcp_pkg::ST_ARG;
            end else if (take && is_term && resp != rbcp_pkg::RESP_NONE) begin
               next_state = rbcp_pkg::ST_SEND;
            end
         end
         rbcp_pkg::ST_ARG: begin
            if (take) begin
               if (dig_ok) begin
                  if ((ndig + 3'h1 == maxd) || in_b.eom) next_state = rbcp_pkg::ST_EXEC;
               end else if (kw_hit) begin
                  if (in_b.eom) next_state = rbcp_pkg::ST_EXEC;
               end else begin
                  // the byte that ends the argument is kept and parsed again
                  hold_it    = 1'b1;
                  next_state = rbcp_pkg::ST_EXEC;
               end
            end
         end
         rbcp_pkg::ST_EXEC: begin
            if (exec_wait) next_state = rbcp_pkg::ST_WAIT;
            else if (term && exec_resp != rbcp_pkg::RESP_NONE) next_state = rbcp_pkg::ST_SEND;
            else next_state = rbcp_pkg::ST_IDLE;
         end
         rbcp_pkg::ST_WAIT: begin
            if (ms_tick && ms_left == 16'h1) begin
               next_state = (term && resp != rbcp_pkg::RESP_NONE) ? rbcp_pkg::ST_SEND : rbcp_pkg::ST_IDLE;
            end
         end
         rbcp_pkg::ST_SEND: begin
            if (push && last) next_state = rbcp_pkg::ST_IDLE;
         end
         default: next_state = rbcp_pkg::ST_BOOT;
      endcase
      next_held_v = hold_it | (held_v & ~(take & (state == rbcp_pkg::ST_IDLE || state == rbcp_pkg::ST_ARG)));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state   <= rbcp_pkg::ST_BOOT;
         pwr_cnt <= 26'h0;
      end else begin
         state <= next_state;
         if (state == rbcp_pkg::ST_BOOT) pwr_cnt <= pwr_cnt + 26'h1;
      end
   end

   // millisecond enable; restarted at each command so a delay is never short
   always_ff @(posedge clk) begin
      if (rst) begin
         pscale    <= 14'h0;
         ms_tick   <= 1'b0;
         blink_cnt <= 8'h0;
         power_led <= 1'b0;
         msg_led   <= 1'b0;
      end else begin
         ms_tick <= 1'b0;
         if (state == rbcp_pkg::ST_EXEC || pscale == 14'(MS_CYC - 1)) pscale <= 14'h0;
         else pscale <= pscale + 14'h1;
         if (state != rbcp_pkg::ST_EXEC && pscale == 14'(MS_CYC - 1)) ms_tick <= 1'b1;
         power_led <= 1'b1;
         if (state == rbcp_pkg::ST_BOOT) begin
            if (ms_tick) begin
               blink_cnt <= (blink_cnt == rbcp_pkg::BLINK_MS - 8'h1) ? 8'h0 : blink_cnt + 8'h1;
               if (blink_cnt == rbcp_pkg::BLINK_MS - 8'h1) msg_led <= ~msg_led;
            end
         end else begin
            msg_led <= 1'b0;
         end
      end
   end

   // registered ready: a byte is only offered when the parser can surely take it
   always_ff @(posedge clk) begin
      if (rst) begin
         held_v   <= 1'b0;
         held     <= '0;
         rx_ready <= 1'b0;
      end else begin
         held_v   <= next_held_v;
         if (hold_it) held <= in_b;
         rx_ready <= (next_state == rbcp_pkg::ST_IDLE || next_state == rbcp_pkg::ST_ARG) && !next_held_v;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cmd  <= 8'h0;
         kwi  <= 3'h0;
         ndig <= 3'h0;
         acc  <= 17'h0;
         bcd  <= 20'h0;
         term <= 1'b0;
      end else if (take && state == rbcp_pkg::ST_IDLE && is_cmd) begin
         cmd  <= c;
         kwi  <= 3'h0;
         ndig <= 3'h0;
         acc  <= 17'h0;
         bcd  <= 20'h0;
         term <= in_b.eom;
      end else if (take && state == rbcp_pkg::ST_ARG && !hold_it) begin
         term <= in_b.eom;
         if (dig_ok) begin
            acc  <= 17'(acc * 17'd10 + 17'(dval));
            bcd  <= {bcd[15:0], dval};
            ndig <= ndig + 3'h1;
         end else begin
            kwi <= kwi + 3'h1;
         end
      end else if (state == rbcp_pkg::ST_SEND && next_state == rbcp_pkg::ST_IDLE) begin
         term <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         relay    <= 32'h0;
         chan_led <= 32'h0;
         sel      <= 5'h0;
         dly      <= 16'h0;
         dly_bcd  <= 20'h0;
         resp     <= rbcp_pkg::RESP_NONE;
         ms_left  <= 16'h0;
      end else begin
         if (state == rbcp_pkg::ST_EXEC) begin
            resp    <= exec_resp;
            ms_left <= dly;
            case (cmd)
               rbcp_pkg::CMD_CLOSE: if (valid_idx) begin
                  relay[idx]    <= 1'b1;
                  chan_led[idx] <= 1'b1;
                  sel           <= idx;
               end
               rbcp_pkg::CMD_OPEN: if (valid_idx) begin
                  relay[idx]    <= 1'b0;
                  chan_led[idx] <= 1'b0;
                  sel           <= idx;
               end
               rbcp_pkg::CMD_QUERY: if (valid_idx) sel <= idx;
               rbcp_pkg::CMD_RESET: if (ndig == 3'h0 || valid_idx) begin
                  relay    <= 32'h0;
                  chan_led <= 32'h0;
                  if (valid_idx) sel <= idx;
               end
               rbcp_pkg::CMD_SET: if (ndig == 3'h0 || valid_idx) begin
                  relay    <= 32'hffffffff;
                  chan_led <= 32'hffffffff;
                  if (valid_idx) sel <= idx;
               end
               rbcp_pkg::CMD_DELAY: if (ndig != 3'h0 && acc <= rbcp_pkg::MAX_DLY) begin
                  dly     <= acc[15:0];
                  dly_bcd <= bcd;
               end
               default: ;
            endcase
         end else if (state == rbcp_pkg::ST_WAIT && ms_tick) begin
            ms_left <= ms_left - 16'h1;
         end else if (state == rbcp_pkg::ST_SEND && push && last) begin
            resp <= rbcp_pkg::RESP_NONE;
         end
      end
   end

   // reply bytes: body, then cr, then lf carrying end-of-message
   always_comb begin
      lead = 3'h4;
      for (int k = 4; k >= 0; k--) begin
         if (dly_bcd[19 - 4 * k -: 4] != 4'h0) lead = 3'(k);
      end
      case (resp)
         rbcp_pkg::RESP_STAT: body_len = rbcp_pkg::STAT_LEN;
         rbcp_pkg::RESP_TIME: body_len = rbcp_pkg::TIME_LEN;
         default:             body_len = rbcp_pkg::ID_LEN;
      endcase
      if (sidx == body_len) begin
         out_c = rbcp_pkg::ASC_CR;
      end else if (sidx > body_len) begin
         out_c = rbcp_pkg::ASC_LF;
      end else if (resp == rbcp_pkg::RESP_STAT) begin
         out_c = rbcp_pkg::ASC_ZERO + {7'h0, relay[sel]};
      end else if (resp == rbcp_pkg::RESP_TIME) begin
         out_c = rbcp_pkg::ASC_ZERO + {4'h0, dly_bcd[19 - 4 * int'(sidx) -: 4]};
      end else begin
         out_c = rbcp_pkg::ID_STR[8 * (int'(rbcp_pkg::ID_LEN) - 1 - int'(sidx)) +: 8];
      end
      last        = (sidx > body_len);
      skip        = (state == rbcp_pkg::ST_SEND) && (resp == rbcp_pkg::RESP_TIME) && (sidx < 5'(lead));
      push        = (state == rbcp_pkg::ST_SEND) && !skip && !spare_v;
      push_b.data = out_c;
      push_b.eom  = last;
   end

   always_ff @(posedge clk) begin
      if (rst) sidx <= 5'h0;
      else if (state != rbcp_pkg::ST_SEND) sidx <= 5'h0;
      else if (skip || push) sidx <= sidx + 5'h1;
   end

   // two-entry output buffer: tx is the head, spare the second word;
   // a stalled reader fills spare and then stops the reply walk
   always_ff @(posedge clk) begin
      if (rst) begin
         tx       <= '0;
         tx_valid <= 1'b0;
         spare    <= '0;
         spare_v  <= 1'b0;
      end else if (!tx_valid || tx_ready) begin
         if (spare_v) begin
            tx       <= spare;
            tx_valid <= 1'b1;
            spare_v  <= push;
            if (push) spare <= push_b;
         end else begin
            tx_valid <= push;
            if (push) tx <= push_b;
         end
      end else if (push) begin
         spare   <= push_b;
         spare_v <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) ws_unsup_err <= 1'b0;
      else ws_unsup_err <= ws_cmd_valid & ~ws_cmd_supported;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_boot_quiet;
      // the indicator is cleared by reset, so the first cycle after release is left out
      (state == rbcp_pkg::ST_BOOT && !$past(rst)) |-> (relay == 32'h0) && !rx_ready && power_led;
   endproperty
   a_boot_quiet: assert property (p_boot_quiet) else $error("relay or ready active during boot");

   property p_close;
      (state == rbcp_pkg::ST_EXEC && cmd == rbcp_pkg::CMD_CLOSE && valid_idx) |=> relay[$past(idx)] && sel == $past(idx);
   endproperty
   a_close: assert property (p_close) else $error("close did not close and select relay");

   property p_open;
      (state == rbcp_pkg::ST_EXEC && cmd == rbcp_pkg::CMD_OPEN && valid_idx)
         |=> relay == ($past(relay) & ~(32'h1 << $past(idx)));
   endproperty
   a_open: assert property (p_open) else $error("open touched wrong relays");

   property p_bad_index;
      (state == rbcp_pkg::ST_EXEC && ndig != 3'h0 && acc > rbcp_pkg::MAX_IDX && cmd != rbcp_pkg::CMD_DELAY)
         |=> relay == $past(relay) && state != rbcp_pkg::ST_WAIT;
   endproperty
   a_bad_index: assert property (p_bad_index) else $error("out-of-range index acted");

   property p_wait_blocks;
      (state == rbcp_pkg::ST_WAIT) ##1 (state == rbcp_pkg::ST_WAIT) |-> !rx_ready;
   endproperty
   a_wait_blocks: assert property (p_wait_blocks) else $error("byte accepted during delay");

   property p_wait_len;
      (state == rbcp_pkg::ST_WAIT) |-> (ms_left != 16'h0) && (ms_left <= dly);
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("delay count out of range");

   property p_all;
      (state == rbcp_pkg::ST_EXEC && (cmd == rbcp_pkg::CMD_SET || cmd == rbcp_pkg::CMD_RESET) && ndig == 3'h0)
         |=> relay == (cmd == rbcp_pkg::CMD_SET ? 32'hffffffff : 32'h0) && state != rbcp_pkg::ST_WAIT;
   endproperty
   a_all: assert property (p_all) else $error("set or reset all wrong");

   property p_led;
      chan_led == relay;
   endproperty
   a_led: assert property (p_led) else $error("channel indicator mismatch");

   property p_eom_on_lf;
      push |-> (push_b.eom == (push_b.data == rbcp_pkg::ASC_LF));
   endproperty
   a_eom_on_lf: assert property (p_eom_on_lf) else $error("eom not on line feed");

   property p_send_after_term;
      $rose(state == rbcp_pkg::ST_SEND) |-> $past(term) || $past(is_term);
   endproperty
   a_send_after_term: assert property (p_send_after_term) else $error("reply before terminator");

   property p_unsup;
      (ws_cmd_valid && !ws_cmd_supported) |=> ws_unsup_err;
   endproperty
   a_unsup: assert property (p_unsup) else $error("unsupported command not flagged");

   c_close:  cover property (state == rbcp_pkg::ST_EXEC && cmd == rbcp_pkg::CMD_CLOSE && valid_idx);
   c_wait:   cover property (state == rbcp_pkg::ST_WAIT ##1 state == rbcp_pkg::ST_IDLE);
   c_reply:  cover property (push && push_b.eom);
   c_stall:  cover property (spare_v && tx_valid && !tx_ready);
endmodule : rbcp_top

// ==== sim/rbcp_reader.sv ====
// reply reader model standing for the bus commander, with an optional stall
`timescale 1ns/1ps
module rbcp_reader (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic stall,
   output logic      tx_ready
);
   logic [1:0] cnt;
   // no transfer timeout here: the reader waits out any hold-off
   always_ff @(posedge clk) begin
      if (rst) cnt <= 2'h0;
      else cnt <= cnt + 2'h1;
   end
   // stalling takes one byte in four, slow enough to fill the two-entry buffer
   always_ff @(posedge clk) begin
      if (rst) tx_ready <= 1'b0;
      else tx_ready <= !stall || cnt == 2'h3;
   end
endmodule : rbcp_reader

// ==== sim/rbcp_top_bench.sv ====
// self-checking testbench of the relay bank command parser
`timescale 1ns/1ps
module rbcp_top_bench;
   localparam int unsigned MS = 10;
   // boot long enough for the message indicator to blink once
   localparam int unsigned PWR = 3000;
   logic                 clk = 1'b0;
   logic                 rst = 1'b1;
   rbcp_pkg::rbcp_byte_s rx = '0;
   logic                 rx_valid = 1'b0;
   logic                 rx_ready;
   rbcp_pkg::rbcp_byte_s tx;
   logic                 tx_valid;
   logic                 tx_ready;
   logic                 ws_v = 1'b0;
   logic                 ws_s = 1'b0;
   logic                 ws_err;
   logic [31:0]          relay;
   logic [31:0]          chan_led;
   logic                 power_led;
   logic                 msg_led;
   logic                 stall = 1'b0;
   logic [8:0]           rq[$];
   int                   fail_count = 0;
   int                   tests_run = 0;
   int                   cyc = 0;
   int                   n;

   rbcp_top #(.PWRUP_CYC(PWR), .MS_CYC(MS)) u_rbcp_top (
      .clk(clk), .rst(rst), .rx(rx), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx(tx),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .ws_cmd_valid(ws_v), .ws_cmd_supported(ws_s),
      .ws_unsup_err(ws_err), .relay(relay), .chan_led(chan_led), .power_led(power_led), .msg_led(msg_led));
   rbcp_reader u_rbcp_reader (.clk(clk), .rst(rst), .stall(stall), .tx_ready(tx_ready));

   initial begin
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rq.push_back(tx);
      cyc <= cyc + 1;
      // the whole run needs a few thousand cycles
      if (cyc == 20000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic test_done;
      $display("counts: %0d mismatches in %0d comparisons", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wait_rdy(output int k);
      k = 0;
      while (rx_ready !== 1'b1 && k < 3000) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_rdy

   // valid stays up across the string so no edge sees it assigned twice
   task automatic run(input string s, input logic e, output int k);
      int w;
      w = 0;
      @(posedge clk);
      rx_valid <= 1'b1;
      for (int i = 0; i < s.len(); i++) begin
         rx <= '{s[i], e && i == s.len() - 1};
         do @(posedge clk); while (rx_ready !== 1'b1 && ++w < 3000);
      end
      rx_valid <= 1'b0;
      @(posedge clk);
      wait_rdy(k);
   endtask : run

   task automatic reply(input string s);
      int w;
      string t;
      w = 0;
      t = {s, "\r\n"};
      while (rq.size() < t.len() && w < 3000) begin
         @(posedge clk);
         w++;
      end
      chk("reply length", t.len(), rq.size());
      for (int i = 0; i < t.len() && i < rq.size(); i++)
         chk("reply byte", {t[i], i == t.len() - 1}, rq[i]);
      rq.delete();
   endtask : reply

   task automatic t_boot;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (50) @(posedge clk);
      chk("boot ready", 0, rx_ready);
      chk("boot relays", 0, relay);
      chk("power led", 1, power_led);
      // first blink toggle falls one blink period into boot
      repeat (int'(rbcp_pkg::BLINK_MS) * MS) @(posedge clk);
      chk("msg led blink", 1, msg_led);
      wait_rdy(n);
      chk("boot time", 1, n > PWR - 2560 && n < PWR - 2540);
      @(posedge clk);
      chk("msg led", 0, msg_led);
   endtask : t_boot

   task automatic t_relay(input string s, input logic e, input logic [31:0] exp);
      run(s, e, n);
      chk({"relay ", s}, exp, relay);
      chk("channel led", exp, chan_led);
   endtask : t_relay

   task automatic t_query;
      stall <= 1'b1;
      run("Q01", 1'b0, n);
      repeat (10) @(posedge clk);
      chk("early reply", 0, rq.size());
      run("\n", 1'b0, n);
      reply("1");
      stall <= 1'b0;
   endtask : t_query

   task automatic t_delay;
      run("D3", 1'b1, n);
      run("C0", 1'b1, n);
      chk("close hold", 1, n >= 3 * MS && n <= 3 * MS + 8);
      chk("relay 0", 32'h80000003, relay);
      run("C32", 1'b1, n);
      chk("bad index hold", 1, n < MS);
      chk("bad index relay", 32'h80000003, relay);
      run("T", 1'b1, n);
      reply("3");
      run("S", 1'b1, n);
      chk("set all", 32'hffffffff, relay);
      chk("set no hold", 1, n < MS);
      run("R00", 1'b1, n);
      chk("reset all", 0, relay);
      chk("reset hold", 1, n >= 3 * MS && n <= 3 * MS + 8);
   endtask : t_delay

   task automatic t_ident;
      int semi;
      semi = 0;
      run("idn?\n", 1'b0, n);
      foreach (rq[i]) semi += (rq[i][8:1] == ";");
      chk("id fields", 3, semi);
      reply($sformatf("%s", rbcp_pkg::ID_STR));
   endtask : t_ident

   task automatic t_ws(input logic sup);
      @(posedge clk);
      ws_v <= 1'b1;
      ws_s <= sup;
      @(posedge clk);
      ws_v <= 1'b0;
      @(posedge clk);
      chk("unsupported error", !sup, ws_err);
   endtask : t_ws

   initial begin
      t_boot();
      t_relay("C05", 1'b0, 32'h00000020);
      t_relay("c31", 1'b0, 32'h80000020);
      t_relay("CLOSE1O05", 1'b1, 32'h80000002);
      t_query();
      t_delay();
      t_ident();
      t_ws(1'b0);
      t_ws(1'b1);
      test_done();
   end
endmodule : rbcp_top_bench
